// ==== oas_consts.svh ====
`ifndef OAS_CONSTS_SVH
`define OAS_CONSTS_SVH
// Register-file location of the stack pointer.
`define OAS_STACK_POINTER_ADDR 8'hD9
// Recommended software start value and the upper bound of a legal start.
`define OAS_SP_RECOMMENDED 8'hC0
`define OAS_SP_LIMIT 8'hC0
// Working register window size and the base of the common area.
`define OAS_WREG_WINDOW 8
`define OAS_WREG_BASE 8'hC0
`endif

// ==== oas_pkg.sv ====
package oas_pkg;
	// Operand addressing modes as presented by the instruction decoder.
	typedef enum logic [2:0] {
		OAS_MODE_REGISTER = 3'h0,
		OAS_MODE_POINTER_VIA_REGISTER = 3'h1,
		OAS_MODE_INDEXED = 3'h2,
		OAS_MODE_ABSOLUTE_OPERAND = 3'h3,
		OAS_MODE_VECTOR_TABLE = 3'h4,
		OAS_MODE_PC_OFFSET = 3'h5,
		OAS_MODE_LITERAL_OPERAND = 3'h6
	} oas_mode_t;

	// Instruction classes that matter to address generation.
	typedef enum logic [3:0] {
		OAS_INSTR_OTHER = 4'h0,
		OAS_INSTR_REGISTER_MOVE = 4'h1,
		OAS_INSTR_PROGRAM_MEMORY_LOAD = 4'h2,
		OAS_INSTR_EXTERNAL_DATA_LOAD = 4'h3,
		OAS_INSTR_ABSOLUTE_JUMP = 4'h4,
		OAS_INSTR_CALL = 4'h5,
		OAS_INSTR_RELATIVE_BRANCH = 4'h6,
		OAS_INSTR_SUBROUTINE_EXIT = 4'h7,
		OAS_INSTR_INTERRUPT_EXIT = 4'h8,
		OAS_INSTR_PUSH = 4'h9,
		OAS_INSTR_POP = 4'hA,
		OAS_INSTR_INTERRUPT_ENTRY = 4'hB
	} oas_instr_t;

	// Memory space that an effective address points into.
	typedef enum logic [1:0] {
		OAS_SPACE_REGFILE = 2'h0,
		OAS_SPACE_PROGRAM = 2'h1,
		OAS_SPACE_EXTERNAL = 2'h2,
		OAS_SPACE_NONE = 2'h3
	} oas_space_t;

	// Stack sequencer states, one-hot.
	typedef enum logic [6:0] {
		OAS_ST_IDLE = 7'b0000001,
		OAS_ST_PUSH_LO = 7'b0000010,
		OAS_ST_PUSH_HI = 7'b0000100,
		OAS_ST_PUSH_FL = 7'b0001000,
		OAS_ST_POP_FL = 7'b0010000,
		OAS_ST_POP_HI = 7'b0100000,
		OAS_ST_POP_LO = 7'b1000000
	} oas_state_t;
endpackage : oas_pkg

// ==== oas_operand_stack_unit.sv ====
`timescale 1ns/1ps
`include "oas_consts.svh"

// Notes on behaviour
// RULE_01: Decrement before push, increment after pop.
// RULE_02: Call saves PC; subroutine exit restores it.
// RULE_03: Interrupt saves PC and flags; exit restores both.
// RULE_04: Eight-bit pointer at D9H, reset leaves undefined.
// RULE_05: Software starts pointer between 00H and C0H.
// RULE_06: 00H wraps to FFH; C0H recommended start.
// RULE_07: Register mode reads named register or pair.
// RULE_08: Pointer picks 8-byte window, field picks register.
// RULE_09: Register holds address; pairs address memory.
// RULE_10: Register-file index: instruction base plus register.
// RULE_11: Memory index: register pair plus instruction offset.
// RULE_12: Short offset sign-extended, external memory only.
// RULE_13: Indexed only for move, program, external loads.
// RULE_14: Absolute mode carries 16 bits; jumps load PC.
// RULE_15: Memory loads use absolute source or destination.
// RULE_16: Vector table in lowest 256 bytes, upper zero.
// RULE_17: Vector-table mode only for subroutine call.
// RULE_18: Relative branch adds signed byte to PC.
// RULE_19: Relative base is the following instruction address.
// RULE_20: Relative mode only for relative branch.
// RULE_21: Literal operand comes from instruction field.
// RULE_22: Pairs: even address high byte, odd low.
// RULE_23: Pointer arithmetic wraps modulo 256 silently.
module oas_operand_stack_unit import oas_pkg::*; #(
	parameter int PC_WIDTH = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic op_valid,
	input wire oas_instr_t op_instr,
	input wire oas_mode_t op_mode,
	input wire logic op_wide,
	input wire logic op_short,
	input wire logic op_dest_mem,
	input wire logic [7:0] op_reg_field,
	input wire logic [15:0] op_imm,
	input wire logic [7:0] op_push_data,
	input wire logic [PC_WIDTH-1:0] pc_next,
	input wire logic [7:0] flags_in,
	input wire logic [7:0] reg_pointer,
	output logic [7:0] rf_rd_addr,
	input wire logic [7:0] rf_rd_data,
	output logic rf_wr_en,
	output logic [7:0] rf_wr_addr,
	output logic [7:0] rf_wr_data,
	output logic [15:0] mem_addr,
	output oas_space_t ea_space,
	output logic [15:0] operand,
	output logic operand_valid,
	output logic mode_fault,
	output logic [PC_WIDTH-1:0] pc_load,
	output logic pc_load_en,
	output logic [7:0] flags_load,
	output logic flags_load_en,
	output logic [7:0] pop_data,
	output logic pop_data_valid,
	output logic stack_busy,
	output logic [7:0] stack_pointer_out
);
	initial begin
		if (PC_WIDTH < 8 || PC_WIDTH > 16) begin
			$error("PC_WIDTH must lie between 8 and 16");
		end
	end

	// Working register address: window from pointer, index from field.
	function automatic logic [7:0] wreg_addr(input logic [7:0] rp,
		input logic [2:0] idx);
		wreg_addr = {rp[7:3], idx}; // see RULE_08
	endfunction : wreg_addr

	// Address of one byte of a pair; even is high, odd is low.
	function automatic logic [7:0] pair_addr(input logic [7:0] a,
		input logic lo);
		pair_addr = {a[7:1], lo}; // see RULE_22
	endfunction : pair_addr

	logic [7:0] stack_pointer_r;
	logic [7:0] stack_pointer_nxt;
	oas_state_t state_r;
	logic [7:0] hi_r;
	logic [7:0] pair_hi_r;
	logic [7:0] base_addr;
	logic [7:0] ptr_hi_r;
	logic [1:0] phase_r;
	logic mode_ok;

	// Which instructions may use which modes.
	always_comb begin
		case (op_mode)
			OAS_MODE_INDEXED: mode_ok = (op_instr == OAS_INSTR_REGISTER_MOVE)
				|| (op_instr == OAS_INSTR_PROGRAM_MEMORY_LOAD)
				|| (op_instr == OAS_INSTR_EXTERNAL_DATA_LOAD); // see RULE_13
			OAS_MODE_VECTOR_TABLE:
				mode_ok = (op_instr == OAS_INSTR_CALL); // see RULE_17
			OAS_MODE_PC_OFFSET:
				mode_ok = (op_instr == OAS_INSTR_RELATIVE_BRANCH); // see RULE_20
			default: mode_ok = 1'b1;
		endcase
	end

	// Short offsets exist only toward external memory.
	logic short_ok;
	assign short_ok = !op_short
		|| (op_instr == OAS_INSTR_EXTERNAL_DATA_LOAD); // see RULE_12

	assign base_addr = op_reg_field[7:4] == 4'hE
		? wreg_addr(reg_pointer, op_reg_field[2:0]) : op_reg_field;

	// Effective address, operand fetch in two phases for 16-bit values.
	// Phase 0 reads the high byte, phase 1 the low byte; the decoder
	// holds the request until operand_valid.
	logic fetch_active;
	assign fetch_active = op_valid && state_r == OAS_ST_IDLE
		&& mode_ok && short_ok;

	logic [15:0] pair_val;
	assign pair_val = {pair_hi_r, rf_rd_data};

	logic [7:0] rd_addr_c;
	always_comb begin
		rd_addr_c = base_addr;
		case (op_mode)
			OAS_MODE_REGISTER:
				rd_addr_c = op_wide ? pair_addr(base_addr, phase_r[0])
					: base_addr; // see RULE_07
			OAS_MODE_POINTER_VIA_REGISTER: begin
				if (op_wide) begin
					rd_addr_c = pair_addr(base_addr, phase_r[0]); // see RULE_09
				end else if (phase_r == 2'd0) begin
					rd_addr_c = base_addr;
				end else begin
					rd_addr_c = ptr_hi_r;
				end
			end
			OAS_MODE_INDEXED:
				rd_addr_c = op_instr == OAS_INSTR_REGISTER_MOVE
					? wreg_addr(reg_pointer, op_reg_field[2:0])
					: pair_addr(base_addr, phase_r[0]); // see RULE_11
			default: rd_addr_c = base_addr;
		endcase
	end

	// Stack reads override operand reads, both in pop sequences and in a
	// single pop, which must read the top entry and not the register field.
	always_comb begin
		case (state_r)
			OAS_ST_POP_FL, OAS_ST_POP_HI, OAS_ST_POP_LO:
				rf_rd_addr = stack_pointer_r;
			default: rf_rd_addr = (fetch_active && op_instr == OAS_INSTR_POP)
				? stack_pointer_r : rd_addr_c; // see RULE_01
		endcase
	end

	// Number of read phases needed before the result stands.
	logic last_phase;
	always_comb begin
		case (op_mode)
			OAS_MODE_REGISTER: last_phase = !op_wide || phase_r == 2'd1;
			OAS_MODE_POINTER_VIA_REGISTER:
				last_phase = phase_r == 2'd1;
			OAS_MODE_INDEXED: last_phase = op_instr == OAS_INSTR_REGISTER_MOVE
				|| phase_r == 2'd1;
			default: last_phase = 1'b1;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst || !fetch_active || last_phase) begin
			phase_r <= 2'd0;
		end else begin
			phase_r <= phase_r + 2'd1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pair_hi_r <= 8'h00;
			ptr_hi_r <= 8'h00;
		end else if (fetch_active && !last_phase) begin
			pair_hi_r <= rf_rd_data;
			ptr_hi_r <= rf_rd_data;
		end
	end

	// Result registers.
	logic [15:0] disp;
	assign disp = op_short ? {{8{op_imm[7]}}, op_imm[7:0]} // see RULE_12
		: op_imm;

	logic [PC_WIDTH-1:0] rel_target;
	assign rel_target = pc_next
		+ PC_WIDTH'({{8{op_imm[7]}}, op_imm[7:0]}); // see RULE_18 RULE_19

	always_ff @(posedge clk) begin
		if (rst) begin
			operand <= 16'h0000;
			mem_addr <= 16'h0000;
			ea_space <= OAS_SPACE_NONE;
			operand_valid <= 1'b0;
			mode_fault <= 1'b0;
		end else begin
			operand_valid <= 1'b0;
			mode_fault <= op_valid && state_r == OAS_ST_IDLE
				&& !(mode_ok && short_ok);
			if (fetch_active && last_phase) begin
				operand_valid <= 1'b1;
				ea_space <= OAS_SPACE_NONE;
				case (op_mode)
					OAS_MODE_REGISTER: begin
						operand <= op_wide ? pair_val
							: {8'h00, rf_rd_data}; // see RULE_07
						ea_space <= OAS_SPACE_REGFILE;
					end
					OAS_MODE_POINTER_VIA_REGISTER: begin
						if (op_wide) begin
							mem_addr <= pair_val; // see RULE_09
							ea_space <= op_instr == OAS_INSTR_EXTERNAL_DATA_LOAD
								? OAS_SPACE_EXTERNAL : OAS_SPACE_PROGRAM;
						end else begin
							mem_addr <= {8'h00, ptr_hi_r};
							operand <= {8'h00, rf_rd_data};
							ea_space <= OAS_SPACE_REGFILE;
						end
					end
					OAS_MODE_INDEXED: begin
						if (op_instr == OAS_INSTR_REGISTER_MOVE) begin
							mem_addr <= {8'h00, op_imm[7:0] + rf_rd_data}; // see RULE_10
							ea_space <= OAS_SPACE_REGFILE;
						end else begin
							mem_addr <= pair_val + disp; // see RULE_11
							ea_space <= op_instr == OAS_INSTR_EXTERNAL_DATA_LOAD
								? OAS_SPACE_EXTERNAL : OAS_SPACE_PROGRAM;
						end
					end
					OAS_MODE_ABSOLUTE_OPERAND: begin
						mem_addr <= op_imm; // see RULE_14 RULE_15
						if (op_instr == OAS_INSTR_EXTERNAL_DATA_LOAD) begin
							ea_space <= OAS_SPACE_EXTERNAL;
						end else begin
							ea_space <= OAS_SPACE_PROGRAM;
						end
						operand <= {15'h0000, op_dest_mem};
					end
					OAS_MODE_VECTOR_TABLE: begin
						mem_addr <= {8'h00, op_imm[7:0]}; // see RULE_16
						ea_space <= OAS_SPACE_PROGRAM;
					end
					OAS_MODE_PC_OFFSET: mem_addr <= 16'(rel_target);
					OAS_MODE_LITERAL_OPERAND: operand <= op_imm; // see RULE_21
					default: operand <= 16'h0000;
				endcase
			end
		end
	end

	// Program counter loads for jumps and branches; a vector-table call
	// leaves the final fetch of the stored pair to the program memory path.
	logic start_call;
	assign start_call = fetch_active && last_phase
		&& (op_instr == OAS_INSTR_CALL || op_instr == OAS_INSTR_INTERRUPT_ENTRY);

	always_ff @(posedge clk) begin
		if (rst) begin
			pc_load <= '0;
			pc_load_en <= 1'b0;
		end else begin
			pc_load_en <= 1'b0;
			if (fetch_active && last_phase && op_mode == OAS_MODE_ABSOLUTE_OPERAND
				&& (op_instr == OAS_INSTR_ABSOLUTE_JUMP
				|| op_instr == OAS_INSTR_CALL)) begin
				pc_load <= op_imm[PC_WIDTH-1:0]; // see RULE_14
				pc_load_en <= 1'b1;
			end else if (fetch_active && op_mode == OAS_MODE_PC_OFFSET) begin
				pc_load <= rel_target; // see RULE_18
				pc_load_en <= 1'b1;
			end else if (state_r == OAS_ST_POP_LO) begin
				pc_load <= PC_WIDTH'({hi_r, rf_rd_data}); // see RULE_02 RULE_03
				pc_load_en <= 1'b1;
			end
		end
	end

	// Stack sequencer. Pushes store the low PC byte first so that the
	// high byte ends at the lower address, matching pair byte order.
	oas_state_t state_nxt;
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			OAS_ST_IDLE: begin
				if (start_call) begin
					state_nxt = OAS_ST_PUSH_LO; // see RULE_02 RULE_03
				end else if (fetch_active && (op_instr == OAS_INSTR_SUBROUTINE_EXIT
					|| op_instr == OAS_INSTR_INTERRUPT_EXIT)) begin
					state_nxt = op_instr == OAS_INSTR_INTERRUPT_EXIT
						? OAS_ST_POP_FL : OAS_ST_POP_HI;
				end
			end
			OAS_ST_PUSH_LO: state_nxt = OAS_ST_PUSH_HI;
			OAS_ST_PUSH_HI: state_nxt = op_instr == OAS_INSTR_INTERRUPT_ENTRY
				? OAS_ST_PUSH_FL : OAS_ST_IDLE;
			OAS_ST_PUSH_FL: state_nxt = OAS_ST_IDLE;
			OAS_ST_POP_FL: state_nxt = OAS_ST_POP_HI;
			OAS_ST_POP_HI: state_nxt = OAS_ST_POP_LO;
			OAS_ST_POP_LO: state_nxt = OAS_ST_IDLE;
			default: state_nxt = OAS_ST_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_r <= OAS_ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	logic push_now;
	logic pop_now;
	assign push_now = state_r == OAS_ST_PUSH_LO || state_r == OAS_ST_PUSH_HI
		|| state_r == OAS_ST_PUSH_FL
		|| (fetch_active && op_instr == OAS_INSTR_PUSH);
	assign pop_now = state_r == OAS_ST_POP_FL || state_r == OAS_ST_POP_HI
		|| state_r == OAS_ST_POP_LO
		|| (fetch_active && op_instr == OAS_INSTR_POP);

	// Pushes write at the decremented pointer; pops read at the current
	// one and step afterwards. Both wrap silently.
	logic [7:0] sp_dec;
	assign sp_dec = stack_pointer_r - 8'h01; // see RULE_01 RULE_06 RULE_23

	logic rf_wr_en_ext;
	logic [7:0] rf_wr_addr_ext;
	assign rf_wr_en_ext = fetch_active && op_instr == OAS_INSTR_REGISTER_MOVE
		&& op_mode != OAS_MODE_INDEXED;
	assign rf_wr_addr_ext = op_reg_field;

	logic sp_write;
	assign sp_write = rf_wr_en_ext && rf_wr_addr_ext == `OAS_STACK_POINTER_ADDR;

	always_comb begin
		stack_pointer_nxt = stack_pointer_r;
		if (sp_write) begin
			stack_pointer_nxt = op_imm[7:0]; // see RULE_04 RULE_05
		end else if (push_now) begin
			stack_pointer_nxt = sp_dec; // see RULE_01
		end else if (pop_now) begin
			stack_pointer_nxt = stack_pointer_r + 8'h01; // see RULE_01 RULE_23
		end
	end

	// No reset: the pointer is undefined until software loads it.
	always_ff @(posedge clk) begin
		stack_pointer_r <= stack_pointer_nxt; // see RULE_04
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rf_wr_en <= 1'b0;
			rf_wr_addr <= 8'h00;
			rf_wr_data <= 8'h00;
		end else begin
			rf_wr_en <= push_now || rf_wr_en_ext;
			rf_wr_addr <= push_now ? sp_dec : rf_wr_addr_ext;
			case (state_r)
				OAS_ST_PUSH_LO: rf_wr_data <= 8'(pc_next);
				OAS_ST_PUSH_HI: rf_wr_data <= 8'(pc_next >> 8);
				OAS_ST_PUSH_FL: rf_wr_data <= flags_in; // see RULE_03
				default: rf_wr_data <= push_now ? op_push_data : op_imm[7:0];
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			hi_r <= 8'h00;
			flags_load <= 8'h00;
			flags_load_en <= 1'b0;
			pop_data <= 8'h00;
			pop_data_valid <= 1'b0;
		end else begin
			flags_load_en <= state_r == OAS_ST_POP_FL; // see RULE_03
			pop_data_valid <= fetch_active && op_instr == OAS_INSTR_POP;
			if (state_r == OAS_ST_POP_FL) begin
				flags_load <= rf_rd_data;
			end
			if (state_r == OAS_ST_POP_HI) begin
				hi_r <= rf_rd_data;
			end
			if (fetch_active && op_instr == OAS_INSTR_POP) begin
				pop_data <= rf_rd_data;
			end
		end
	end

	assign stack_busy = state_r != OAS_ST_IDLE;
	assign stack_pointer_out = stack_pointer_r;
endmodule : oas_operand_stack_unit

// ==== oas_unit_properties.sv ====
`timescale 1ns/1ps

module oas_unit_properties import oas_pkg::*; #(
	parameter int PC_WIDTH = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic op_valid,
	input wire oas_instr_t op_instr,
	input wire oas_mode_t op_mode,
	input wire logic [15:0] op_imm,
	input wire logic [PC_WIDTH-1:0] pc_next,
	input wire logic rf_wr_en,
	input wire logic [7:0] rf_wr_data,
	input wire logic [15:0] operand,
	input wire logic operand_valid,
	input wire logic mode_fault,
	input wire logic [PC_WIDTH-1:0] pc_load,
	input wire logic pc_load_en,
	input wire logic stack_busy,
	input wire logic [7:0] stack_pointer_out
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	sp_step_a: assert property (
		$past(stack_busy) && stack_pointer_out != $past(stack_pointer_out)
		|-> stack_pointer_out - $past(stack_pointer_out) inside {8'h01, 8'hFF})
		else $error("stack pointer stepped by more than one");
	rel_target_a: assert property (
		$rose(op_valid) && !stack_busy && op_mode == OAS_MODE_PC_OFFSET &&
		op_instr == OAS_INSTR_RELATIVE_BRANCH |=> pc_load_en &&
		pc_load == $past(pc_next) +
		{{8{$past(op_imm[7])}}, $past(op_imm[7:0])})
		else $error("relative branch target wrong");
	jump_target_a: assert property (
		$rose(op_valid) && !stack_busy && op_instr == OAS_INSTR_ABSOLUTE_JUMP
		&& op_mode == OAS_MODE_ABSOLUTE_OPERAND
		|=> pc_load_en && pc_load == $past(op_imm))
		else $error("jump target wrong");
	literal_value_a: assert property (
		$rose(op_valid) && !stack_busy && op_instr == OAS_INSTR_REGISTER_MOVE
		&& op_mode == OAS_MODE_LITERAL_OPERAND
		|=> operand_valid && operand == $past(op_imm))
		else $error("literal operand wrong");
	call_push_a: assert property (
		$rose(op_valid) && !stack_busy && op_instr == OAS_INSTR_CALL &&
		op_mode == OAS_MODE_ABSOLUTE_OPERAND |=> pc_load_en && stack_busy
		##[1:3] rf_wr_en && rf_wr_data == pc_next[7:0])
		else $error("call did not save the return address");
	vector_only_a: assert property (
		$rose(op_valid) && !stack_busy && op_mode == OAS_MODE_VECTOR_TABLE &&
		op_instr != OAS_INSTR_CALL |=> mode_fault)
		else $error("vector mode accepted outside a call");
	offset_only_a: assert property (
		$rose(op_valid) && !stack_busy && op_mode == OAS_MODE_PC_OFFSET &&
		op_instr != OAS_INSTR_RELATIVE_BRANCH |=> mode_fault)
		else $error("relative mode accepted outside a branch");
	index_only_a: assert property (
		$rose(op_valid) && !stack_busy && op_mode == OAS_MODE_INDEXED &&
		!(op_instr inside {OAS_INSTR_REGISTER_MOVE,
		OAS_INSTR_PROGRAM_MEMORY_LOAD, OAS_INSTR_EXTERNAL_DATA_LOAD})
		|=> mode_fault)
		else $error("indexed mode accepted by a wrong instruction");
endmodule : oas_unit_properties

bind oas_operand_stack_unit oas_unit_properties #(.PC_WIDTH(PC_WIDTH)) u_p (
	.clk(clk), .rst(rst), .op_valid(op_valid), .op_instr(op_instr),
	.op_mode(op_mode), .op_imm(op_imm), .pc_next(pc_next),
	.rf_wr_en(rf_wr_en), .rf_wr_data(rf_wr_data), .operand(operand),
	.operand_valid(operand_valid), .mode_fault(mode_fault),
	.pc_load(pc_load), .pc_load_en(pc_load_en), .stack_busy(stack_busy),
	.stack_pointer_out(stack_pointer_out)
);

// ==== oas_operand_stack_unit_tb.sv ====
`timescale 1ns/1ps

module oas_operand_stack_unit_tb import oas_pkg::*;;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic op_valid = 1'b0, op_wide = 1'b0, op_short = 1'b0;
	logic op_dest_mem = 1'b0;
	oas_instr_t op_instr = OAS_INSTR_OTHER;
	oas_mode_t op_mode = OAS_MODE_REGISTER;
	logic [7:0] op_reg_field = 8'h00, op_push_data = 8'h00;
	logic [7:0] flags_in = 8'h00, reg_pointer = 8'hC0;
	logic [15:0] op_imm = 16'h0000, pc_next = 16'h0000;
	logic [7:0] rf_rd_addr, rf_rd_data, rf_wr_addr, rf_wr_data;
	logic [7:0] flags_load, pop_data, stack_pointer_out, fl_cap, pop_cap;
	logic rf_wr_en, operand_valid, mode_fault, pc_load_en, flags_load_en;
	logic pop_data_valid, stack_busy, last_fault;
	logic [15:0] mem_addr, operand, pc_load, pc_cap;
	oas_space_t ea_space;
	logic [7:0] rf [256];
	oas_instr_t fi [5] = '{OAS_INSTR_OTHER, OAS_INSTR_ABSOLUTE_JUMP,
		OAS_INSTR_REGISTER_MOVE, OAS_INSTR_OTHER,
		OAS_INSTR_PROGRAM_MEMORY_LOAD};
	oas_mode_t fm [5] = '{OAS_MODE_VECTOR_TABLE, OAS_MODE_VECTOR_TABLE,
		OAS_MODE_PC_OFFSET, OAS_MODE_INDEXED, OAS_MODE_INDEXED};
	logic fs [5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
	int n_errors = 0;
	int checks = 0;

	assign rf_rd_data = rf[rf_rd_addr];
	always #20 clk = ~clk;

	oas_operand_stack_unit #(.PC_WIDTH(16)) DUT (
		.clk, .rst, .op_valid, .op_instr, .op_mode, .op_wide, .op_short,
		.op_dest_mem, .op_reg_field, .op_imm, .op_push_data, .pc_next,
		.flags_in, .reg_pointer, .rf_rd_addr, .rf_rd_data, .rf_wr_en,
		.rf_wr_addr, .rf_wr_data, .mem_addr, .ea_space, .operand,
		.operand_valid, .mode_fault, .pc_load, .pc_load_en, .flags_load,
		.flags_load_en, .pop_data, .pop_data_valid, .stack_busy,
		.stack_pointer_out
	);

	// Pulses are caught here because stack phases end after the answer.
	always @(posedge clk) begin
		if (rf_wr_en === 1'b1)
			rf[rf_wr_addr] <= rf_wr_data;
		if (pc_load_en === 1'b1)
			pc_cap <= pc_load;
		if (flags_load_en === 1'b1)
			fl_cap <= flags_load;
		if (pop_data_valid === 1'b1)
			pop_cap <= pop_data;
	end

	task automatic print_verdict();
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : print_verdict

	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		checks++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic chk_sp(input logic [7:0] e);
		chk("stack pointer", {8'h00, e}, {8'h00, stack_pointer_out});
	endtask : chk_sp

	task automatic chk_rf(input logic [7:0] a, input logic [7:0] e);
		chk("stack byte", {8'h00, e}, {8'h00, rf[a]});
	endtask : chk_rf

	// Holds the request until an answer shows, then lets the stack settle.
	task automatic req(input oas_instr_t i, input oas_mode_t m);
		int n;
		n = 0;
		op_instr = i;
		op_mode = m;
		op_valid = 1'b1;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while ((operand_valid | mode_fault | pop_data_valid | rf_wr_en |
			pc_load_en) !== 1'b1 && n < 20);
		last_fault = mode_fault;
		op_valid = 1'b0;
		while (stack_busy !== 1'b0 && n < 40) begin
			@(posedge clk);
			#1;
			n++;
		end
		repeat (2) @(posedge clk);
		#1;
		op_wide = 1'b0;
		op_short = 1'b0;
		op_dest_mem = 1'b0;
		chk("handshake", 16'h0000, {15'h0000, n >= 20});
	endtask : req

	task automatic push(input logic [7:0] d);
		op_push_data = d;
		req(OAS_INSTR_PUSH, OAS_MODE_REGISTER);
	endtask : push

	task automatic setsp(input logic [7:0] v);
		op_reg_field = 8'hD9;
		op_imm = {8'h00, v};
		req(OAS_INSTR_REGISTER_MOVE, OAS_MODE_LITERAL_OPERAND);
	endtask : setsp

	// A hung handshake must still reach the verdict well inside the budget.
	initial begin
		#2000000;
		n_errors++;
		print_verdict();
	end

	initial begin
		for (int k = 0; k < 256; k++)
			rf[k] = 8'h00;
		repeat (20) @(posedge clk);
		#1;
		rst = 1'b0;
		setsp(8'hC0);
		chk("literal", 16'h00C0, operand);
		chk_sp(8'hC0);
		push(8'h5A);
		push(8'hA5);
		chk_rf(8'hBE, 8'hA5);
		chk_sp(8'hBE);
		req(OAS_INSTR_POP, OAS_MODE_REGISTER);
		chk("pop", 16'h00A5, {8'h00, pop_cap});
		chk_sp(8'hBF);
		req(OAS_INSTR_POP, OAS_MODE_REGISTER);
		chk("pop", 16'h005A, {8'h00, pop_cap});
		pc_next = 16'h0456;
		op_imm = 16'h1234;
		req(OAS_INSTR_CALL, OAS_MODE_ABSOLUTE_OPERAND);
		chk("pc", 16'h1234, pc_cap);
		chk_rf(8'hBF, 8'h56);
		chk_rf(8'hBE, 8'h04);
		req(OAS_INSTR_SUBROUTINE_EXIT, OAS_MODE_REGISTER);
		chk("pc", 16'h0456, pc_cap);
		chk_sp(8'hC0);
		pc_next = 16'h0ABC;
		flags_in = 8'h3C;
		req(OAS_INSTR_INTERRUPT_ENTRY, OAS_MODE_REGISTER);
		chk_rf(8'hBD, 8'h3C);
		chk_sp(8'hBD);
		req(OAS_INSTR_INTERRUPT_EXIT, OAS_MODE_REGISTER);
		chk("flags", 16'h003C, {8'h00, fl_cap});
		chk("pc", 16'h0ABC, pc_cap);
		setsp(8'h00);
		push(8'h77);
		chk_rf(8'hFF, 8'h77);
		chk_sp(8'hFF);
		rf[8'h22] = 8'h12;
		rf[8'h23] = 8'h34;
		op_reg_field = 8'h22;
		op_wide = 1'b1;
		req(OAS_INSTR_OTHER, OAS_MODE_REGISTER);
		chk("operand", 16'h1234, operand);
		rf[8'hCB] = 8'h6E;
		reg_pointer = 8'hC8;
		op_reg_field = 8'hE3;
		req(OAS_INSTR_OTHER, OAS_MODE_REGISTER);
		chk("operand", 16'h006E, operand);
		op_reg_field = 8'h22;
		op_wide = 1'b1;
		req(OAS_INSTR_PROGRAM_MEMORY_LOAD,
			OAS_MODE_POINTER_VIA_REGISTER);
		chk("address", 16'h1234, mem_addr);
		rf[8'h30] = 8'h22;
		op_reg_field = 8'h30;
		req(OAS_INSTR_OTHER, OAS_MODE_POINTER_VIA_REGISTER);
		chk("operand", 16'h0012, operand);
		chk("address", 16'h0022, mem_addr);
		reg_pointer = 8'hC0;
		rf[8'hC2] = 8'h05;
		op_reg_field = 8'hE2;
		op_imm = 16'h0010;
		req(OAS_INSTR_REGISTER_MOVE, OAS_MODE_INDEXED);
		chk("address", 16'h0015, mem_addr);
		chk("space", {14'h0000, OAS_SPACE_REGFILE}, {14'h0000, ea_space});
		rf[8'hC4] = 8'h20;
		op_reg_field = 8'hE4;
		op_imm = 16'h00FF;
		op_wide = 1'b1;
		op_short = 1'b1;
		req(OAS_INSTR_EXTERNAL_DATA_LOAD, OAS_MODE_INDEXED);
		chk("address", 16'h1FFF, mem_addr);
		op_imm = 16'h0100;
		op_wide = 1'b1;
		req(OAS_INSTR_PROGRAM_MEMORY_LOAD, OAS_MODE_INDEXED);
		chk("address", 16'h2100, mem_addr);
		op_imm = 16'h3456;
		op_dest_mem = 1'b1;
		req(OAS_INSTR_EXTERNAL_DATA_LOAD,
			OAS_MODE_ABSOLUTE_OPERAND);
		chk("address", 16'h3456, mem_addr);
		chk("direction", 16'h0001, {15'h0000, operand[0]});
		pc_next = 16'h0100;
		op_imm = 16'h0080;
		req(OAS_INSTR_RELATIVE_BRANCH, OAS_MODE_PC_OFFSET);
		chk("pc", 16'h0080, pc_cap);
		op_imm = 16'hABCD;
		req(OAS_INSTR_ABSOLUTE_JUMP, OAS_MODE_ABSOLUTE_OPERAND);
		chk("pc", 16'hABCD, pc_cap);
		setsp(8'hC0);
		op_imm = 16'h0042;
		req(OAS_INSTR_CALL, OAS_MODE_VECTOR_TABLE);
		chk("address", 16'h0042, mem_addr);
		for (int k = 0; k < 5; k++) begin
			op_short = fs[k];
			req(fi[k], fm[k]);
			chk("fault", 16'h0001, {15'h0000, last_fault});
		end
		// A reset in mid-run must leave the pointer where the last call left it.
		rst = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		rst = 1'b0;
		chk_sp(8'hBE);
		print_verdict();
	end
endmodule : oas_operand_stack_unit_tb
